/* File: umc_pkg.sv */
// Purpose: Shared constants for the serial channel control/status block
// Assumes: Register select is the classic 3-bit channel address
// Notes: Offsets follow the usual eight-register channel map
package umc_pkg;
    // Register select values (3-bit channel address)
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_QCTL = 3'h2; // Write: queue control
    localparam logic [2:0] ADDR_IID = 3'h2;  // Read: source id
    localparam logic [2:0] ADDR_HCTL = 3'h4;
    localparam logic [2:0] ADDR_HSTAT = 3'h6;
    localparam logic [2:0] ADDR_SCRATCH = 3'h7;
    // Enable register bits
    localparam int IE_RDA = 0;
    localparam int IE_THRE = 1;
    localparam int IE_RLS = 2;
    localparam int IE_MS = 3;
    // Queue control bits
    localparam int QC_EN = 0;
    localparam int QC_RXFL = 1;
    localparam int QC_TXFL = 2;
    localparam int QC_DMA = 3;
    localparam int QC_TRIG_LO = 6;
    // Handshake control bits
    localparam int HC_DTR = 0;
    localparam int HC_RTS = 1;
    localparam int HC_AUX = 2;
    localparam int HC_OE = 3;
    localparam int HC_LOOP = 4;
    // Reset values
    localparam logic [7:0] IER_RST = 8'h00;
    localparam logic [7:0] HCTL_RST = 8'h00;
    localparam logic [7:0] SCR_RST = 8'h00;
    localparam logic [7:0] QC_RST = 8'h00;
    // Trigger levels in bytes
    localparam logic [4:0] TRIG_1 = 5'h01;
    localparam logic [4:0] TRIG_4 = 5'h04;
    localparam logic [4:0] TRIG_8 = 5'h08;
    localparam logic [4:0] TRIG_14 = 5'h0E;
    // Timeout span in character times
    localparam logic [2:0] TO_CHARS = 3'h4;
    // Source id codes
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [3:0] ID_RLS = 4'h6;
    localparam logic [3:0] ID_RDA = 4'h4;
    localparam logic [3:0] ID_TO = 4'hC;
    localparam logic [3:0] ID_THRE = 4'h2;
    localparam logic [3:0] ID_MS = 4'h0;
    // Timeout watcher states
    typedef enum logic [1:0] {
        UMC_TO_IDLE = 2'b00,
        UMC_TO_RUN = 2'b01,
        UMC_TO_FIRED = 2'b11
    } umc_to_state_t;
endpackage : umc_pkg

/* File: umc_timeout.sv */
// Purpose: Receive queue character timeout watcher
// Assumes: char_tick pulses once per character time incl. any second stop
// Notes: Restarts on every reception or host read of the queue
module umc_timeout
    import umc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Conditions
    input wire logic armed,
    input wire logic rx_nonempty,
    input wire logic char_tick,
    input wire logic rx_push,
    input wire logic rx_pop,
    // Result
    output logic timeout
);
    umc_to_state_t state, next_state;
    logic [2:0] cnt, next_cnt;

    // Count character times with activity restarting the watch
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        if (!armed || !rx_nonempty || rx_pop || rx_push) begin
            next_state = (armed && rx_nonempty) ? UMC_TO_RUN : UMC_TO_IDLE;
            next_cnt = 3'h0;
        end else begin
            case (state)
                UMC_TO_IDLE: begin
                    next_state = UMC_TO_RUN;
                    next_cnt = 3'h0;
                end
                UMC_TO_RUN: begin
                    if (char_tick) begin
                        next_cnt = cnt + 3'h1;
                        if (cnt + 3'h1 == TO_CHARS) begin
                            next_state = UMC_TO_FIRED;
                        end
                    end
                end
                UMC_TO_FIRED: next_state = UMC_TO_FIRED;
                default: next_state = UMC_TO_IDLE;
            endcase
        end
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state <= UMC_TO_IDLE;
            cnt <= 3'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    assign timeout = (state == UMC_TO_FIRED);

    property p_to_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        rx_pop |=> !timeout;
    endproperty
    a_to_clear: assert property (p_to_clear)
        else $error("timeout not cleared by host read");
endmodule : umc_timeout

/* File: umc_ctrl.sv */
// Purpose: Control and status of one serial channel: enables, scratch,
//          queue control, handshake outputs, loopback, input status
// Assumes: Host strobes are synchronous single-cycle pulses
// Notes: Shift registers, baud timing and queues live outside;
//        this block drives their control and reads their status
//
// What this block does
// - Each enabled source reaches the interrupt pin only with output-enable bit set.
// - Enable bits 0-3 select data, holding-empty, line, modem; 4-7 read zero.
// - All enables clear suppresses identification and interrupt; status still updates.
// - Scratch byte is read/write and affects nothing else.
// - Queue control write-only, shares address with read-only identification.
// - Bit 0 enables queues; clearing it empties both queues.
// - Other queue control bits update only when bit 0 is written one.
// - Bits 1 and 2 flush receive and transmit queues, then self clear.
// - Bit 3 with queues enabled selects DMA signalling mode 1.
// - Bits 7:6 select receive trigger 1, 4, 8 or 14 bytes.
// - Control bits 0 and 1 drive DTR and RTS inverted.
// - Output-enable bit clear tri-states the interrupt pin.
// - Loopback holds serial output high and feeds transmit into receive.
// - In loopback status bits 4-7 follow RTS, DTR, bit 2, bit 3.
// - Loopback tri-states the interrupt pin regardless of output enable.
// - In loopback interrupts still work, modem ones from control bits.
// - Change bits set on input change; reading status clears them all.
// - Bits 0,1,3 flag any change; bit 2 only ring on-to-off.
// - Any change bit set raises the modem status interrupt.
// - Status bits 4-7 report complements of the four inputs.
// - Timeout interrupt after four idle character times with data queued.
// - Timeout scales with baud; host read clears it and restarts.
module umc_ctrl
    import umc_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Host register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    // Status from the data path
    input wire logic rx_ready,
    input wire logic [4:0] rx_count,
    input wire logic rx_push,
    input wire logic rx_pop,
    input wire logic char_tick,
    input wire logic thr_empty,
    input wire logic line_err,
    input wire logic tx_shift_out,
    input wire logic tx_room,
    // Control to the data path
    output logic queue_mode,
    output logic rx_flush,
    output logic tx_flush,
    output logic rx_shift_in,
    // DMA request pins
    output logic rx_dma_request,
    output logic tx_dma_request,
    // Serial pins
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    // Modem pins, active low
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic ring_n,
    input wire logic carrier_detect_input_n,
    output logic dtr_n,
    output logic rts_n,
    // Interrupt pin
    output logic irq_out,
    output logic irq_oe
);
    logic [3:0] irq_enable_reg, next_ier;
    logic [7:0] scratch, next_scratch;
    logic [7:0] handshake_control_reg, next_hcr;
    logic queue_enable_bit, next_qen;
    logic dma_signal_mode_bit, next_dma;
    logic [1:0] trig_sel, next_trig;
    logic rx_flush_q, next_rx_flush;
    logic tx_flush_q, next_tx_flush;
    logic [3:0] delta, next_delta;
    logic [3:0] sync1, sync2, prev;
    logic [3:0] live, next_prev;
    logic [7:0] next_rd;
    logic next_irq, next_irq_oe, next_txp, next_dtr, next_rts;
    logic next_rxdma, next_txdma, next_rxin;
    logic [4:0] trig_lvl;
    logic to_hit, tmo, rda, thre, rls, ms, any_irq;
    logic [3:0] id_code;
    logic loop;

    assign loop = handshake_control_reg[HC_LOOP];

    // Input synchroniser; first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync1 <= 4'hF;
            sync2 <= 4'hF;
        end else begin
            sync1 <= {carrier_detect_input_n, ring_n, dsr_n, cts_n};
            sync2 <= sync1;
        end
    end

    // Present state {dcd, ring, dsr, cts}, active high
    always_comb begin
        if (loop) begin
            live = {handshake_control_reg[HC_OE],
                    handshake_control_reg[HC_AUX],
                    handshake_control_reg[HC_DTR],
                    handshake_control_reg[HC_RTS]};
        end else begin
            live = ~sync2;
        end
    end

    // Receive queue timeout watcher
    umc_timeout u_to (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .armed(queue_enable_bit && irq_enable_reg[IE_RDA]),
        .rx_nonempty(rx_count != 5'h00),
        .char_tick(char_tick),
        .rx_push(rx_push),
        .rx_pop(rx_pop),
        .timeout(to_hit)
    );

    // Trigger level decode
    always_comb begin
        case (trig_sel)
            2'b00: trig_lvl = TRIG_1;
            2'b01: trig_lvl = TRIG_4;
            2'b10: trig_lvl = TRIG_8;
            2'b11: trig_lvl = TRIG_14;
            default: trig_lvl = TRIG_1;
        endcase
    end

    // Interrupt conditions gated by their enables
    always_comb begin
        rda = irq_enable_reg[IE_RDA] &&
              (queue_enable_bit ? (rx_count >= trig_lvl) : rx_ready);
        thre = irq_enable_reg[IE_THRE] && thr_empty;
        rls = irq_enable_reg[IE_RLS] && line_err;
        ms = irq_enable_reg[IE_MS] && (delta != 4'h0);
        // Watcher state lags the enables by a cycle; gate it here too
        tmo = to_hit && irq_enable_reg[IE_RDA] && queue_enable_bit;
        any_irq = rls || rda || tmo || thre || ms;
        if (rls) id_code = ID_RLS;
        else if (rda) id_code = ID_RDA;
        else if (tmo) id_code = ID_TO;
        else if (thre) id_code = ID_THRE;
        else if (ms) id_code = ID_MS;
        else id_code = ID_NONE;
    end

    // Register write, flush pulses and change detection
    always_comb begin
        next_ier = irq_enable_reg;
        next_scratch = scratch;
        next_hcr = handshake_control_reg;
        next_qen = queue_enable_bit;
        next_dma = dma_signal_mode_bit;
        next_trig = trig_sel;
        next_rx_flush = 1'b0;
        next_tx_flush = 1'b0;
        next_prev = live;
        next_delta = delta;
        if (wr_stb) begin
            case (reg_addr)
                ADDR_IER: next_ier = wr_data[3:0];
                ADDR_SCRATCH: next_scratch = wr_data;
                ADDR_HCTL: next_hcr = {3'h0, wr_data[4:0]};
                ADDR_QCTL: begin
                    next_qen = wr_data[QC_EN];
                    if (!wr_data[QC_EN]) begin
                        next_rx_flush = queue_enable_bit;
                        next_tx_flush = queue_enable_bit;
                    end else begin
                        next_rx_flush = wr_data[QC_RXFL];
                        next_tx_flush = wr_data[QC_TXFL];
                        next_dma = wr_data[QC_DMA];
                        next_trig = wr_data[QC_TRIG_LO +: 2];
                    end
                end
                default: ;
            endcase
        end
        // Read clears first, so a change in the same cycle survives
        if (rd_stb && reg_addr == ADDR_HSTAT) begin
            next_delta = 4'h0;
        end
        next_delta[0] = next_delta[0] | (live[0] ^ prev[0]);
        next_delta[1] = next_delta[1] | (live[1] ^ prev[1]);
        next_delta[2] = next_delta[2] | (prev[2] & ~live[2]);
        next_delta[3] = next_delta[3] | (live[3] ^ prev[3]);
    end

    // Registered pin and read data values
    always_comb begin
        case (reg_addr)
            ADDR_IER: next_rd = {4'h0, irq_enable_reg};
            ADDR_IID: next_rd = {{2{queue_enable_bit}}, 2'b00,
                                 any_irq ? id_code : ID_NONE};
            ADDR_HCTL: next_rd = handshake_control_reg;
            ADDR_HSTAT: next_rd = {live, delta};
            ADDR_SCRATCH: next_rd = scratch;
            default: next_rd = 8'h00;
        endcase
        next_dtr = ~next_hcr[HC_DTR];
        next_rts = ~next_hcr[HC_RTS];
        next_irq_oe = next_hcr[HC_OE] && !next_hcr[HC_LOOP];
        next_irq = any_irq && handshake_control_reg[HC_OE];
        next_txp = next_hcr[HC_LOOP] ? 1'b1 : tx_shift_out;
        next_rxin = loop ? tx_shift_out : serial_rx_pin;
        if (queue_enable_bit && dma_signal_mode_bit) begin
            next_rxdma = !((rx_count >= trig_lvl) || to_hit);
            next_txdma = !tx_room;
        end else begin
            next_rxdma = !rx_ready;
            next_txdma = !thr_empty;
        end
    end

    // Register stage; every output leaves from here
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_enable_reg <= IER_RST[3:0];
            scratch <= SCR_RST;
            handshake_control_reg <= HCTL_RST;
            queue_enable_bit <= QC_RST[QC_EN];
            dma_signal_mode_bit <= QC_RST[QC_DMA];
            trig_sel <= QC_RST[QC_TRIG_LO +: 2];
            rx_flush_q <= 1'b0;
            tx_flush_q <= 1'b0;
            delta <= 4'h0;
            prev <= 4'h0;
            rd_data <= 8'h00;
            dtr_n <= 1'b1;
            rts_n <= 1'b1;
            irq_out <= 1'b0;
            irq_oe <= 1'b0;
            serial_tx_pin <= 1'b1;
            rx_shift_in <= 1'b1;
            rx_dma_request <= 1'b1;
            tx_dma_request <= 1'b1;
        end else begin
            irq_enable_reg <= next_ier;
            scratch <= next_scratch;
            handshake_control_reg <= next_hcr;
            queue_enable_bit <= next_qen;
            dma_signal_mode_bit <= next_dma;
            trig_sel <= next_trig;
            rx_flush_q <= next_rx_flush;
            tx_flush_q <= next_tx_flush;
            delta <= next_delta;
            prev <= next_prev;
            rd_data <= next_rd;
            dtr_n <= next_dtr;
            rts_n <= next_rts;
            irq_out <= next_irq;
            irq_oe <= next_irq_oe;
            serial_tx_pin <= next_txp;
            rx_shift_in <= next_rxin;
            rx_dma_request <= next_rxdma;
            tx_dma_request <= next_txdma;
        end
    end

    assign queue_mode = queue_enable_bit;
    assign rx_flush = rx_flush_q;
    assign tx_flush = tx_flush_q;

    property p_enable_hi_zero;
        @(posedge ref_clk) disable iff (sys_rst)
        rd_stb && reg_addr == ADDR_IER |=> rd_data[7:4] == 4'h0;
    endproperty
    a_enable_hi_zero: assert property (p_enable_hi_zero)
        else $error("enable upper bits not zero");

    property p_irq_gate;
        @(posedge ref_clk) disable iff (sys_rst)
        irq_out |-> $past(handshake_control_reg[HC_OE]) && $past(any_irq);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without enable");

    property p_no_enables;
        @(posedge ref_clk) disable iff (sys_rst)
        irq_enable_reg == 4'h0 |=> !irq_out;
    endproperty
    a_no_enables: assert property (p_no_enables)
        else $error("interrupt with all enables clear");

    property p_scratch;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_stb && reg_addr == ADDR_SCRATCH |=> scratch == $past(wr_data);
    endproperty
    a_scratch: assert property (p_scratch)
        else $error("scratch not stored");

    property p_flush_pulse;
        @(posedge ref_clk) disable iff (sys_rst)
        rx_flush |=> !rx_flush || $past(wr_stb && reg_addr == ADDR_QCTL);
    endproperty
    a_flush_pulse: assert property (p_flush_pulse)
        else $error("flush did not self clear");

    property p_qctl_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        wr_stb && reg_addr == ADDR_QCTL && !wr_data[QC_EN] |=>
            $stable(trig_sel) && $stable(dma_signal_mode_bit);
    endproperty
    a_qctl_hold: assert property (p_qctl_hold)
        else $error("queue control bits changed while disabled");

    property p_dtr;
        @(posedge ref_clk) disable iff (sys_rst)
        ##1 dtr_n == !handshake_control_reg[HC_DTR];
    endproperty
    a_dtr: assert property (p_dtr)
        else $error("dtr not inverse of control");

    property p_loop_pins;
        @(posedge ref_clk) disable iff (sys_rst)
        loop |-> serial_tx_pin && !irq_oe;
    endproperty
    a_loop_pins: assert property (p_loop_pins)
        else $error("loopback pins wrong");

    property p_delta_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        rd_stb && reg_addr == ADDR_HSTAT && live == prev |=> delta == 4'h0;
    endproperty
    a_delta_clear: assert property (p_delta_clear)
        else $error("change bits not cleared by read");

    property p_cts_change;
        @(posedge ref_clk) disable iff (sys_rst)
        live[0] != prev[0] |=> delta[0];
    endproperty
    a_cts_change: assert property (p_cts_change)
        else $error("cts change missed");
endmodule : umc_ctrl

/* File: umc_modem_model.sv */
// Purpose: Behavioural data set driving the four handshake inputs
// Assumes: Lines are active low and idle high (inactive)
// Notes: Levels follow the request LAG cycles later, off the clock
//        edge, since a real data set is not tied to our clock
module umc_modem_model #(
    parameter int LAG = 2
) (
    // Clock of the channel, used only to pace the lag
    input wire logic ref_clk,
    // Requested levels {carrier, ring, dsr, cts}
    input wire logic [3:0] want_n,
    // Lines toward the channel
    output logic cts_n,
    output logic dsr_n,
    output logic ring_n,
    output logic carrier_detect_input_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Lines start inactive
    initial begin
        {carrier_detect_input_n, ring_n, dsr_n, cts_n} = 4'hF;
    end

    // Apply each new request after the lag, mid-cycle
    always begin
        @(want_n);
        repeat (LAG) @(posedge ref_clk);
        #3 {carrier_detect_input_n, ring_n, dsr_n, cts_n} = want_n;
    end
endmodule : umc_modem_model

/* File: testbench.sv */
// Purpose: Self-checking bench for the channel control/status block
// Assumes: Reads answer one cycle after the strobe edge
// Notes: Pin checks wait a few cycles so registered outputs settle
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import umc_pkg::*;

    logic ref_clk = 0, sys_rst = 1, wr_stb = 0, rd_stb = 0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] wr_data = 8'h00, rd_data, v, base_r, base_t;
    logic rx_ready = 0, rx_push = 0, rx_pop = 0, char_tick = 0;
    logic thr_empty = 0, line_err = 0, tx_shift_out = 0, tx_room = 0;
    logic [4:0] rx_count = 5'h00;
    logic serial_rx_pin = 1, serial_tx_pin, rx_shift_in;
    logic queue_mode, rx_flush, tx_flush, rx_dma_request, tx_dma_request;
    logic cts_n, dsr_n, ring_n, cd_n, dtr_n, rts_n, irq_out, irq_oe;
    logic [3:0] want_n = 4'hF;
    logic rd_seen = 0;
    logic [7:0] rxf_cnt = 8'h00, txf_cnt = 8'h00;
    logic [7:0] exp_q[$];
    string nm_q[$];
    int num_errors = 0, total_checks = 0, seed = 90596, i;
    // Source table: {line_err, rx_ready, thr_empty}, enables, id code
    logic [2:0] src_in [5] = '{3'h4, 3'h2, 3'h1, 3'h7, 3'h7};
    logic [7:0] src_ie [5] = '{8'h04, 8'h01, 8'h02, 8'h0F, 8'h00};
    logic [3:0] src_id [5] = '{ID_RLS, ID_RDA, ID_THRE, ID_RLS, ID_NONE};
    logic [4:0] trig [4] = '{TRIG_1, TRIG_4, TRIG_8, TRIG_14};
    logic [7:0] fl_val [3] = '{8'h0B, 8'h0D, 8'h00};
    logic [7:0] fl_exp [3] = '{8'h01, 8'h10, 8'h11};
    logic [2:0] zaddr [7] = '{3'h1, 3'h4, 3'h7, 3'h6, 3'h0, 3'h3, 3'h5};

    umc_ctrl umc_ctrl_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data), .rx_ready(rx_ready),
        .rx_count(rx_count), .rx_push(rx_push), .rx_pop(rx_pop),
        .char_tick(char_tick), .thr_empty(thr_empty), .line_err(line_err),
        .tx_shift_out(tx_shift_out), .tx_room(tx_room),
        .queue_mode(queue_mode), .rx_flush(rx_flush), .tx_flush(tx_flush),
        .rx_shift_in(rx_shift_in), .rx_dma_request(rx_dma_request),
        .tx_dma_request(tx_dma_request), .serial_rx_pin(serial_rx_pin),
        .serial_tx_pin(serial_tx_pin), .cts_n(cts_n), .dsr_n(dsr_n),
        .ring_n(ring_n), .carrier_detect_input_n(cd_n), .dtr_n(dtr_n),
        .rts_n(rts_n), .irq_out(irq_out), .irq_oe(irq_oe));

    umc_modem_model #(.LAG(2)) umc_modem_model_inst (.ref_clk(ref_clk),
        .want_n(want_n), .cts_n(cts_n), .dsr_n(dsr_n), .ring_n(ring_n),
        .carrier_detect_input_n(cd_n));

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [7:0] ex,
                       input logic [7:0] got);
        total_checks++;
        if (got !== ex) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 reg_addr = a;
        wr_data = d;
        wr_stb = 1;
        @(posedge ref_clk);
        #1 wr_stb = 0;
    endtask : wr

    // Note the expectation, strobe once, wait for the answer edge
    task automatic rd(input logic [2:0] a, input logic [7:0] ex,
                      input string nm);
        @(posedge ref_clk);
        #1 reg_addr = a;
        rd_stb = 1;
        exp_q.push_back(ex);
        nm_q.push_back(nm);
        @(posedge ref_clk);
        #1 rd_stb = 0;
        @(posedge ref_clk);
        #1;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    // One-cycle pulse on {char_tick, rx_push, rx_pop}
    task automatic pulse(input logic [2:0] m);
        @(posedge ref_clk);
        #1 {char_tick, rx_push, rx_pop} = m;
        @(posedge ref_clk);
        #1 {char_tick, rx_push, rx_pop} = 3'h0;
    endtask : pulse

    task automatic final_report;
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report

    // Read data lands one edge after the strobe; counters count flushes
    always @(posedge ref_clk) begin
        if (rd_seen) begin
            chk(nm_q.pop_front(), exp_q.pop_front(), rd_data);
        end
        rd_seen <= rd_stb;
        if (!sys_rst) begin
            rxf_cnt <= rxf_cnt + 8'(rx_flush);
            txf_cnt <= txf_cnt + 8'(tx_flush);
        end
    end

    // Hang guard; the whole run needs well under 30 us
    initial begin
        #100us;
        num_errors++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        #1 sys_rst = 0;
        chk("pins", 8'hF3, {dtr_n, rts_n, serial_tx_pin, 1'b1, irq_oe,
            1'b0, rx_dma_request, tx_dma_request});
        rd(ADDR_IID, 8'h01, "id");
        wr(3'h3, 8'hFF);
        foreach (zaddr[k]) rd(zaddr[k], 8'h00, "zero");
        wr(ADDR_IER, 8'hFF);
        rd(ADDR_IER, 8'h0F, "ier");
        for (i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            wr(ADDR_SCRATCH, v);
            rd(ADDR_SCRATCH, v, "scratch");
        end
        rd(ADDR_IER, 8'h0F, "ier");
        // Handshake outputs inverted; serial input passes outside loop
        for (i = 0; i < 4; i++) begin
            serial_rx_pin = i[0];
            wr(ADDR_HCTL, 8'(i));
            idle(3);
            chk("dtr_rts", {6'h00, ~i[1:0]}, {rts_n, dtr_n});
            chk("rx_in", 8'(i[0]), rx_shift_in);
            rd(ADDR_HCTL, 8'(i), "hctl");
        end
        // Interrupt sources, gating, priority, character-mode DMA
        wr(ADDR_HCTL, 8'h08);
        for (i = 0; i < 5; i++) begin
            {line_err, rx_ready, thr_empty} = src_in[i];
            wr(ADDR_IER, src_ie[i]);
            idle(3);
            chk("irq", 8'(src_id[i] != ID_NONE), irq_out);
            chk("irq_oe", 8'h01, irq_oe);
            chk("dma0", 8'({~rx_ready, ~thr_empty}),
                {rx_dma_request, tx_dma_request});
            rd(ADDR_IID, {4'h0, src_id[i]}, "id");
        end
        wr(ADDR_IER, 8'h02);
        wr(ADDR_HCTL, 8'h00);
        idle(3);
        chk("irq_off", 8'h00, {irq_out, irq_oe});
        {line_err, rx_ready, thr_empty} = 3'h0;
        // Loopback: pins, status mirror, change bits, interrupt
        wr(ADDR_IER, 8'h08);
        wr(ADDR_HCTL, 8'h1F);
        for (i = 0; i < 4; i++) begin
            tx_shift_out = 1'($random(seed));
            serial_rx_pin = ~tx_shift_out;
            idle(2);
            chk("loop_rx", 8'(tx_shift_out), rx_shift_in);
            chk("loop_pins", 8'h02, {serial_tx_pin, irq_oe});
        end
        rd(ADDR_HSTAT, 8'hFB, "hstat");
        rd(ADDR_HSTAT, 8'hF0, "hstat");
        wr(ADDR_HCTL, 8'h1B);
        idle(4);
        chk("irq_ms", 8'h01, irq_out);
        rd(ADDR_HSTAT, 8'hB4, "hstat");
        idle(3);
        chk("irq_ms", 8'h00, irq_out);
        wr(ADDR_HCTL, 8'h00);
        idle(4);
        rd(ADDR_HSTAT, 8'h0B, "hstat");
        rd(ADDR_HSTAT, 8'h00, "hstat");
        // Real handshake inputs from the data set
        want_n = 4'hE;
        idle(8);
        rd(ADDR_HSTAT, 8'h11, "hstat");
        rd(ADDR_HSTAT, 8'h10, "hstat");
        want_n = 4'hA;
        idle(8);
        rd(ADDR_HSTAT, 8'h50, "hstat");
        want_n = 4'hE;
        idle(8);
        rd(ADDR_HSTAT, 8'h14, "hstat");
        want_n = 4'h4;
        idle(8);
        rd(ADDR_HSTAT, 8'hBA, "hstat");
        wr(ADDR_HCTL, 8'h08);
        want_n = 4'hF;
        idle(8);
        chk("irq_ms", 8'h01, irq_out);
        rd(ADDR_HSTAT, 8'h0B, "hstat");
        idle(3);
        chk("irq_ms", 8'h00, irq_out);
        wr(ADDR_IER, 8'h00);
        // Queue control gated by bit 0, DMA mode 1, trigger levels
        wr(ADDR_QCTL, 8'hC8);
        idle(3);
        chk("qmode", 8'h00, queue_mode);
        wr(ADDR_QCTL, 8'h0F);
        rx_count = 5'h01;
        tx_room = 1;
        idle(3);
        chk("dma1", 8'h04, {queue_mode, rx_dma_request,
            tx_dma_request});
        for (i = 0; i < 4; i++) begin
            wr(ADDR_QCTL, {i[1:0], 6'h09});
            rx_count = trig[i] - 5'h01;
            tx_room = 0;
            idle(3);
            chk("trig_lo", 8'h03, {rx_dma_request, tx_dma_request});
            rx_count = trig[i];
            idle(3);
            chk("trig", 8'h00, rx_dma_request);
        end
        // Flushes pulse once each; clearing bit 0 empties both
        for (i = 0; i < 3; i++) begin
            base_r = rxf_cnt;
            base_t = txf_cnt;
            wr(ADDR_QCTL, fl_val[i]);
            idle(4);
            chk("flush", fl_exp[i], ((txf_cnt - base_t) << 4)
                | (rxf_cnt - base_r));
        end
        chk("qmode", 8'h00, queue_mode);
        // Character timeout, restart on reception, clear on host read
        wr(ADDR_QCTL, 8'hCF);
        wr(ADDR_IER, 8'h01);
        wr(ADDR_HCTL, 8'h08);
        rx_count = 5'h01;
        repeat (3) pulse(3'h4);
        pulse(3'h2);
        repeat (3) pulse(3'h4);
        idle(3);
        rd(ADDR_IID, {4'hC, ID_NONE}, "id");
        pulse(3'h4);
        idle(3);
        rd(ADDR_IID, {4'hC, ID_TO}, "id");
        chk("irq_to", 8'h02, {irq_out, rx_dma_request});
        pulse(3'h1);
        idle(3);
        rd(ADDR_IID, {4'hC, ID_NONE}, "id");
        chk("irq_to", 8'h00, irq_out);
        final_report();
    end
endmodule : testbench
